// ==== design/clid_consts.svh ====
`ifndef CLID_CONSTS_SVH
`define CLID_CONSTS_SVH

// Instruction opcode bit positions within the data byte.
`define CLID_BIT_CLEAR 0
`define CLID_BIT_HOME 1
`define CLID_BIT_ENTRY 2
`define CLID_BIT_DISP 3
`define CLID_BIT_SHIFT 4

// Fill values used by the clear instruction.
`define CLID_CHAR_BLANK 8'h20
`define CLID_ARB_BLANK 8'h00

// Memory sizes and line geometry.
`define CLID_CHAR_DEPTH 128
`define CLID_ARB_DEPTH 32
`define CLID_LINE_LAST 7'h27
`define CLID_LINE2_BASE 7'h40
`define CLID_LINE_LEN 6'd40

// Oscillator and execution timing.
`define CLID_CLK_HZ 50000000
`define CLID_OSC_HZ 270000
`define CLID_T_LONG_NS 1520000
`define CLID_T_SHORT_NS 37000
// Oscillator period in system clocks, rounded down to whole cycles.
`define CLID_OSC_DIV (`CLID_CLK_HZ / `CLID_OSC_HZ)
// Execution lengths in oscillator cycles, rounded down as longest times.
`define CLID_LONG_OSC ((`CLID_T_LONG_NS * (`CLID_OSC_HZ / 1000)) / 1000000)
`define CLID_SHORT_OSC ((`CLID_T_SHORT_NS * (`CLID_OSC_HZ / 1000)) / 1000000)
// Longest busy times in system clocks, used only by the timing checks.
`define CLID_SHORT_CYC (`CLID_T_SHORT_NS / (1000000000 / `CLID_CLK_HZ))
`define CLID_LONG_CYC (`CLID_T_LONG_NS / (1000000000 / `CLID_CLK_HZ))

`endif

// ==== design/clid_pkg.sv ====
package clid_pkg;
	// Kind of RAM that the address counter currently points into.
	typedef enum logic [1:0] {
		CLID_SEL_CHAR = 2'b00,
		CLID_SEL_PAT = 2'b01,
		CLID_SEL_ARB = 2'b10
	} clid_sel_e;

	// Execution state of the instruction engine.
	typedef enum logic [1:0] {
		CLID_IDLE = 2'b00,
		CLID_CLEAR = 2'b01,
		CLID_WAIT = 2'b10
	} clid_state_e;
endpackage

// ==== design/clid_osc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Oscillator tick and busy timer hand-off between top and timer.
interface clid_osc_if;
	logic tick;
	logic start;
	logic [8:0] count;
	logic done;
	modport timer (output tick, output done, input start, input count);
	modport user (input tick, input done, output start, output count);
endinterface
`default_nettype wire

// ==== design/clid_exec_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clid_consts.svh"
module clid_exec_timer
	import clid_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Link to the instruction engine.
	clid_osc_if.timer osc
);
	logic [7:0] divR;
	logic [8:0] remR;

	// Oscillator tick derived from the system clock; durations count these ticks.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			divR <= 8'h00;
			osc.tick <= 1'b0;
		end else if (divR == 8'(`CLID_OSC_DIV - 1)) begin
			divR <= 8'h00;
			osc.tick <= 1'b1;
		end else begin
			divR <= divR + 8'h01;
			osc.tick <= 1'b0;
		end
	end

	// Remaining oscillator cycles; done pulses when the count expires.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			remR <= 9'h000;
			osc.done <= 1'b0;
		end else if (osc.start) begin
			remR <= osc.count;
			osc.done <= 1'b0;
		end else if (osc.tick && remR != 9'h000) begin
			remR <= remR - 9'h001;
			osc.done <= (remR == 9'h001);
		end else begin
			osc.done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== design/clid_instr_decoder.sv ====
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "clid_consts.svh"
module clid_instr_decoder
	import clid_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Host bus, one-cycle strobes.
	input wire logic selectHi,
	input wire logic selectLo,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData,
	// Access events from the data path and mode state.
	input wire logic ramAccess,
	input wire logic ramWrite,
	input wire logic [1:0] ramSel,
	input wire logic twoLine,
	// Display state outputs.
	output logic busyIndication,
	output logic [6:0] addrCounter,
	output logic [6:0] cursorPos,
	output logic [5:0] dispShift,
	output logic stepUp,
	output logic shiftEnable,
	output logic displayOn,
	output logic cursorShown,
	output logic blinkShown,
	output logic [7:0] charRamOut,
	output logic [7:0] arbRamOut
);
	clid_osc_if osc ();
	clid_state_e stateR;
	logic [7:0] charRam [`CLID_CHAR_DEPTH];
	logic [7:0] arbRam [`CLID_ARB_DEPTH];
	logic [6:0] clrIdxR;
	logic cursorEnR;
	logic blinkEnR;
	logic cmdWr;
	logic statusRd;
	logic startR;
	logic [8:0] countR;

	clid_exec_timer timer (
		.mclk(mclk),
		.rst(rst),
		.osc(osc)
	);

	assign osc.start = startR;
	assign osc.count = countR;

	// Instruction writes are dropped while busy; status reads always pass.
	assign cmdWr = wrStb && selectHi && !selectLo && !busyIndication;
	assign statusRd = rdStb && selectHi && !selectLo;

	// Step of a seven-bit position, with the two-line wrap from 27h to 40h.
	function automatic logic [6:0] stepPos(input logic [6:0] p, input logic up, input logic tl);
		logic [6:0] r;
		r = up ? p + 7'h01 : p - 7'h01;
		if (tl && up && p == `CLID_LINE_LAST)
			r = `CLID_LINE2_BASE;
		else if (tl && !up && p == `CLID_LINE2_BASE)
			r = `CLID_LINE_LAST;
		return r;
	endfunction

	// Shift offset rotates modulo one line length, so lines never mix.
	function automatic logic [5:0] rotShift(input logic [5:0] s, input logic left);
		logic [5:0] r;
		r = 6'h00;
		if (left)
			r = (s == `CLID_LINE_LEN - 6'd1) ? 6'h00 : s + 6'h01;
		else
			r = (s == 6'h00) ? `CLID_LINE_LEN - 6'd1 : s - 6'h01;
		return r;
	endfunction

	// Execution state: clear walks memories, all others just wait on the timer.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stateR <= CLID_IDLE;
			busyIndication <= 1'b0;
			startR <= 1'b0;
			countR <= 9'h000;
			clrIdxR <= 7'h00;
		end else begin
			startR <= 1'b0;
			case (stateR)
				CLID_IDLE: begin
					if (cmdWr && wrData != 8'h00) begin
						busyIndication <= 1'b1;
						startR <= 1'b1;
						if (wrData[7:1] == 7'h00) begin
							countR <= 9'(`CLID_LONG_OSC);
							stateR <= CLID_CLEAR;
							clrIdxR <= 7'h00;
						end else if (wrData[7:2] == 6'h00) begin
							countR <= 9'(`CLID_LONG_OSC);
							stateR <= CLID_WAIT;
						end else begin
							countR <= 9'(`CLID_SHORT_OSC);
							stateR <= CLID_WAIT;
						end
					end
				end
				CLID_CLEAR: begin
					clrIdxR <= clrIdxR + 7'h01;
					if (clrIdxR == 7'h7f)
						stateR <= CLID_WAIT;
				end
				CLID_WAIT: begin
					if (osc.done) begin
						busyIndication <= 1'b0;
						stateR <= CLID_IDLE;
					end
				end
				default: stateR <= CLID_IDLE;
			endcase
		end
	end

	// Memory blanking one word per cycle; clear finishes well inside its time.
	genvar gi;
	generate
		for (gi = 0; gi < `CLID_CHAR_DEPTH; gi++) begin : g_char
			always_ff @(posedge mclk or posedge rst) begin
				if (rst)
					charRam[gi] <= `CLID_CHAR_BLANK;
				else if (stateR == CLID_CLEAR && clrIdxR == 7'(gi))
					charRam[gi] <= `CLID_CHAR_BLANK;
			end
		end
		for (gi = 0; gi < `CLID_ARB_DEPTH; gi++) begin : g_arb
			always_ff @(posedge mclk or posedge rst) begin
				if (rst)
					arbRam[gi] <= `CLID_ARB_BLANK;
				else if (stateR == CLID_CLEAR && clrIdxR == 7'(gi))
					arbRam[gi] <= `CLID_ARB_BLANK;
			end
		end
	endgenerate

	// Entry mode register; clear forces increment and keeps shift enable.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stepUp <= 1'b1;
			shiftEnable <= 1'b0;
		end else if (cmdWr && wrData == 8'h01) begin
			stepUp <= 1'b1;
		end else if (cmdWr && wrData[7:3] == 5'h00 && wrData[2]) begin
			stepUp <= wrData[1];
			shiftEnable <= wrData[0];
		end
	end

	// Display control bits; only gating changes, RAM is never touched here.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			displayOn <= 1'b0;
			cursorEnR <= 1'b0;
			blinkEnR <= 1'b0;
		end else if (cmdWr && wrData[7:4] == 4'h0 && wrData[3]) begin
			displayOn <= wrData[2];
			cursorEnR <= wrData[1];
			blinkEnR <= wrData[0];
		end
	end

	// Visible cursor and blink are gated by the display-on bit.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cursorShown <= 1'b0;
			blinkShown <= 1'b0;
		end else begin
			cursorShown <= cursorEnR && displayOn;
			blinkShown <= blinkEnR && displayOn;
		end
	end

	// Address counter: reset by clear and home, stepped by cursor shifts and accesses.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			addrCounter <= 7'h00;
		end else if (cmdWr && wrData[7:2] == 6'h00 && wrData[1:0] != 2'b00) begin
			addrCounter <= 7'h00;
		end else if (cmdWr && wrData[7:4] == 4'h1 && !wrData[3]) begin
			addrCounter <= stepPos(addrCounter, wrData[2], twoLine);
		end else if (ramAccess) begin
			addrCounter <= stepPos(addrCounter, stepUp, twoLine && ramSel == CLID_SEL_CHAR);
		end
	end

	// Cursor position and display shift offset.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cursorPos <= 7'h00;
			dispShift <= 6'h00;
		end else if (cmdWr && wrData == 8'h01) begin
			cursorPos <= 7'h00;
		end else if (cmdWr && wrData[7:1] == 7'h01) begin
			cursorPos <= 7'h00;
			dispShift <= 6'h00;
		end else if (cmdWr && wrData[7:4] == 4'h1) begin
			if (wrData[3])
				dispShift <= rotShift(dispShift, !wrData[2]);
			else
				cursorPos <= stepPos(cursorPos, wrData[2], twoLine);
		end else if (ramAccess) begin
			if (shiftEnable && ramWrite && ramSel == CLID_SEL_CHAR)
				dispShift <= rotShift(dispShift, stepUp);
			else if (ramSel == CLID_SEL_CHAR || shiftEnable)
				cursorPos <= stepPos(cursorPos, stepUp, twoLine);
		end
	end

	// Status read answers in the following cycle with busy and counter.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rdData <= 8'h00;
		else if (statusRd)
			rdData <= {busyIndication, addrCounter};
		else
			rdData <= 8'h00;
	end

	// Word zero of each memory is exposed so clearing is observable.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			charRamOut <= `CLID_CHAR_BLANK;
			arbRamOut <= `CLID_ARB_BLANK;
		end else begin
			charRamOut <= charRam[0];
			arbRamOut <= arbRam[0];
		end
	end

	// Busy must stay high throughout the clear walk.
	property p_clear_busy;
		@(posedge mclk) disable iff (rst) stateR == CLID_CLEAR |-> busyIndication;
	endproperty
	a_clear_busy: assert property (p_clear_busy) else $error("busy low during clear");

	// Writes during busy must not alter the display-on bit.
	property p_busy_ignore;
		@(posedge mclk) disable iff (rst)
			(busyIndication && wrStb && selectHi && !selectLo) |=> $stable(displayOn);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("instruction taken while busy");

	// A status read answers on the next cycle with busy and counter.
	property p_status;
		@(posedge mclk) disable iff (rst)
			statusRd |=> rdData == {$past(busyIndication), $past(addrCounter)};
	endproperty
	a_status: assert property (p_status) else $error("status read wrong");

	// Cursor is never shown with the display off.
	property p_cursor_gate;
		@(posedge mclk) disable iff (rst) cursorShown |-> $past(displayOn);
	endproperty
	a_cursor_gate: assert property (p_cursor_gate) else $error("cursor shown while off");

	// Blink is never shown with the display off.
	property p_blink_gate;
		@(posedge mclk) disable iff (rst) blinkShown |-> $past(displayOn);
	endproperty
	a_blink_gate: assert property (p_blink_gate) else $error("blink shown while off");

	sequence s_home_cmd;
		cmdWr && wrData[7:1] == 7'h01;
	endsequence

	// Home zeroes counter, cursor and shift in the next cycle.
	property p_home;
		@(posedge mclk) disable iff (rst)
			s_home_cmd |=> (addrCounter == 7'h00 && cursorPos == 7'h00 && dispShift == 6'h00);
	endproperty
	a_home: assert property (p_home) else $error("home did not reset position");

	// Clear forces increment and keeps shift enable.
	property p_clear_mode;
		@(posedge mclk) disable iff (rst)
			(cmdWr && wrData == 8'h01) |=> (stepUp && shiftEnable == $past(shiftEnable));
	endproperty
	a_clear_mode: assert property (p_clear_mode) else $error("clear entry mode wrong");

	logic [16:0] busyCycR;

	// Busy length in system clocks; a delay range could not reach the long budget.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			busyCycR <= 17'h00000;
		else if (busyIndication)
			busyCycR <= busyCycR + 17'h00001;
		else
			busyCycR <= 17'h00000;
	end

	// Short instructions release busy within the 37 us budget.
	property p_short_time;
		@(posedge mclk) disable iff (rst)
			(busyIndication && countR == 9'(`CLID_SHORT_OSC)) |-> busyCycR < 17'(`CLID_SHORT_CYC);
	endproperty
	a_short_time: assert property (p_short_time) else $error("short instruction overran");

	// Clear and home release busy within the 1.52 ms budget.
	property p_long_time;
		@(posedge mclk) disable iff (rst)
			(busyIndication && countR == 9'(`CLID_LONG_OSC)) |-> busyCycR < 17'(`CLID_LONG_CYC);
	endproperty
	a_long_time: assert property (p_long_time) else $error("long instruction overran");

	// A refused write must not move the address counter either.
	property p_busy_ctr;
		@(posedge mclk) disable iff (rst)
			(busyIndication && wrStb && selectHi && !selectLo && !ramAccess) |=> $stable(addrCounter);
	endproperty
	a_busy_ctr: assert property (p_busy_ctr) else $error("counter moved by refused write");

	// Display shift leaves the address counter unchanged.
	property p_dshift_adc;
		@(posedge mclk) disable iff (rst)
			(cmdWr && wrData[7:3] == 5'h03) |=> $stable(addrCounter);
	endproperty
	a_dshift_adc: assert property (p_dshift_adc) else $error("display shift moved counter");
endmodule
`default_nettype wire

// ==== bench/clid_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behavioural host that drives instruction codes and polls the status byte.
module clid_host_model (
	// Clock.
	input wire logic mclk,
	// Status byte returned by the device.
	input wire logic [7:0] rdData,
	// Bus lines driven by the host.
	output var logic selectHi,
	output var logic selectLo,
	output var logic wrStb,
	output var logic rdStb,
	output var logic [7:0] wrData
);
	// Idle cycles before each polled send, so the host can act slow or prompt.
	int gap = 0;

	// Quiet bus at time zero.
	initial begin
		selectHi = 1'h1;
		selectLo = 1'h0;
		wrStb = 1'h0;
		rdStb = 1'h0;
		wrData = 8'h00;
	end

	// One status read; the byte is only valid in the cycle after the strobe.
	task automatic read(output logic [7:0] v);
		@(posedge mclk);
		selectHi <= 1'h1;
		selectLo <= 1'h0;
		rdStb <= 1'h1;
		@(posedge mclk);
		rdStb <= 1'h0;
		#1;
		v = rdData;
	endtask

	// Unchecked write; used alone for the clear after an idle wait and for the refused write.
	task automatic write(input logic [7:0] d);
		@(posedge mclk);
		selectHi <= 1'h1;
		selectLo <= 1'h0;
		wrStb <= 1'h1;
		wrData <= d;
		@(posedge mclk);
		wrStb <= 1'h0;
		wrData <= ~d; // Released lines must not keep showing the last byte.
	endtask

	// Polls until idle, then writes; a stuck device is cut off by the bench timer.
	task automatic send(input logic [7:0] d);
		logic [7:0] v;
		repeat (gap) @(posedge mclk);
		v = 8'hff;
		while (v[7] !== 1'h0) begin
			read(v);
		end
		write(d);
	endtask
endmodule
`default_nettype wire

// ==== bench/clid_instr_decoder_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	nTests++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end
module clid_instr_decoder_tb_top;
	typedef struct packed {
		logic [7:0] cmd;
		logic acc;
		logic wr;
		logic [1:0] sel;
		logic [6:0] ctr;
		logic [6:0] cur;
		logic [5:0] sh;
		logic up;
		logic sen;
		logic d;
		logic c;
		logic b;
	} clid_row_s;
	logic mclk, rst, selectHi, selectLo, wrStb, rdStb, ramAccess, ramWrite, twoLine;
	logic [7:0] wrData, rdData, charRamOut, arbRamOut, v;
	logic [1:0] ramSel;
	logic busyIndication, stepUp, shiftEnable, displayOn, cursorShown, blinkShown;
	logic [6:0] addrCounter, cursorPos;
	logic [5:0] dispShift;
	clid_row_s rows [11];
	clid_row_s r;
	int fails = 0;
	int nTests = 0;
	int cyc = 0;
	int n;

	clid_instr_decoder u_dut (.mclk(mclk), .rst(rst), .selectHi(selectHi),
		.selectLo(selectLo), .wrStb(wrStb), .rdStb(rdStb), .wrData(wrData),
		.rdData(rdData), .ramAccess(ramAccess), .ramWrite(ramWrite), .ramSel(ramSel),
		.twoLine(twoLine), .busyIndication(busyIndication), .addrCounter(addrCounter),
		.cursorPos(cursorPos), .dispShift(dispShift), .stepUp(stepUp),
		.shiftEnable(shiftEnable), .displayOn(displayOn), .cursorShown(cursorShown),
		.blinkShown(blinkShown), .charRamOut(charRamOut), .arbRamOut(arbRamOut));
	clid_host_model u_host (.mclk(mclk), .rdData(rdData), .selectHi(selectHi),
		.selectLo(selectLo), .wrStb(wrStb), .rdStb(rdStb), .wrData(wrData));

	// Free-running 50 MHz clock.
	always #10 mclk = ~mclk;

	// Prints the counts and the verdict, then stops.
	task automatic results;
		$display("checks %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One data RAM access event from the data path.
	task automatic acc(input logic w, input logic [1:0] s);
		@(posedge mclk);
		ramAccess <= 1'h1;
		ramWrite <= w;
		ramSel <= s;
		@(posedge mclk);
		ramAccess <= 1'h0;
	endtask

	// Counts cycles until busy falls, giving up at the limit.
	task automatic waitIdle(input int lim, output int k);
		k = 0;
		#1;
		while (busyIndication !== 1'h0 && k < lim) begin
			@(posedge mclk);
			#1;
			k++;
		end
	endtask

	// Hang guard; one clear alone takes about 76000 cycles.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 110000) begin
			fails++;
			results();
		end
	end

	// Main sequence: table rows first, then line wrap, one-line step, home, mid-run reset and clear.
	initial begin
		mclk = 1'h0;
		rst = 1'h1;
		ramAccess = 1'h0;
		ramWrite = 1'h0;
		ramSel = 2'h0;
		twoLine = 1'h1;
		rows = '{
			'{8'h0f, 1'h0, 1'h0, 2'h0, 7'h00, 7'h00, 6'h00, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1},
			'{8'h0b, 1'h0, 1'h0, 2'h0, 7'h00, 7'h00, 6'h00, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0},
			'{8'h0d, 1'h0, 1'h0, 2'h0, 7'h00, 7'h00, 6'h00, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
			'{8'h14, 1'h0, 1'h0, 2'h0, 7'h01, 7'h01, 6'h00, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
			'{8'h10, 1'h0, 1'h0, 2'h0, 7'h00, 7'h00, 6'h00, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
			'{8'h1c, 1'h0, 1'h0, 2'h0, 7'h00, 7'h00, 6'h27, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
			'{8'h18, 1'h0, 1'h0, 2'h0, 7'h00, 7'h00, 6'h00, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
			'{8'h06, 1'h1, 1'h1, 2'h0, 7'h01, 7'h01, 6'h00, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
			'{8'h04, 1'h1, 1'h0, 2'h1, 7'h00, 7'h01, 6'h00, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1},
			'{8'h07, 1'h1, 1'h1, 2'h0, 7'h01, 7'h01, 6'h01, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1},
			'{8'h05, 1'h1, 1'h0, 2'h2, 7'h00, 7'h00, 6'h01, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1}};
		repeat (20) @(posedge mclk);
		rst <= 1'h0;
		for (int i = 0; i < 11; i++) begin
			r = rows[i];
			u_host.gap = i % 3;
			u_host.send(r.cmd);
			waitIdle(4000, n);
			`CHK("short exec", 1'h1, n <= 1850)
			if (r.acc) begin
				acc(r.wr, r.sel);
			end
			repeat (3) @(posedge mclk);
			#1;
			`CHK("counter", r.ctr, addrCounter)
			`CHK("cursor", r.cur, cursorPos)
			`CHK("shift", r.sh, dispShift)
			`CHK("entry", {r.up, r.sen}, {stepUp, shiftEnable})
			`CHK("show", {r.d, r.c, r.b}, {displayOn, cursorShown, blinkShown})
			u_host.read(v);
			`CHK("status", {1'h0, r.ctr}, v)
		end
		// Step the cursor to the end of line one and one place beyond.
		u_host.send(8'h06);
		waitIdle(4000, n);
		repeat (39) acc(1'h1, 2'h0);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("line end", 7'h27, cursorPos)
		acc(1'h1, 2'h0);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("wrap", {7'h40, 7'h40}, {cursorPos, addrCounter})
		// In one-line mode a step left from 40h must not jump back to 27h.
		@(posedge mclk);
		twoLine <= 1'h0;
		u_host.send(8'h10);
		waitIdle(4000, n);
		`CHK("one line", {7'h3f, 7'h3f}, {cursorPos, addrCounter})
		// Home with bit 0 set; a reset cuts the long wait short.
		u_host.send(8'h03);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("home busy", 1'h1, busyIndication)
		`CHK("home", {7'h00, 7'h00, 6'h00}, {addrCounter, cursorPos, dispShift})
		@(posedge mclk);
		rst <= 1'h1;
		repeat (3) @(posedge mclk);
		#1;
		`CHK("reset", {1'h0, 1'h1, 1'h0, 1'h0, 8'h00, 7'h00},
			{busyIndication, stepUp, shiftEnable, displayOn, rdData, addrCounter})
		@(posedge mclk);
		rst <= 1'h0;
		// Clear from decrement with shift on; a write during busy must be dropped.
		u_host.send(8'h05);
		waitIdle(4000, n);
		u_host.write(8'h01);
		u_host.write(8'h14);
		u_host.read(v);
		`CHK("busy bit", 1'h1, v[7])
		waitIdle(80000, n);
		`CHK("clear exec", 1'h1, n + 4 <= 76000)
		`CHK("clear", {7'h00, 7'h00, 1'h1, 1'h1}, {addrCounter, cursorPos, stepUp, shiftEnable})
		`CHK("blank", {8'h20, 8'h00}, {charRamOut, arbRamOut})
		results();
	end
endmodule
`default_nettype wire
